// file: inc/abx_pkg.sv
package abx_pkg;

    // ----------------------------------------
    // Instruction word layout
    // ----------------------------------------
    localparam int ABX_INSN_W = 14;
    localparam int ABX_ADDR_W = 7;
    localparam int ABX_DEST_BIT = 7;
    localparam int ABX_BIT_LSB = 7;
    localparam int ABX_DATA_W = 8;
    localparam int ABX_FILE_DEPTH = 128;

    // Opcode patterns, compared against the upper bits of the word
    localparam logic [4:0] ABX_OP_ADDLIT = 5'h1f;   // 11 111x
    localparam logic [5:0] ABX_OP_ANDLIT = 6'h39;   // 11 1001
    localparam logic [5:0] ABX_OP_ADDFILE = 6'h07;  // 00 0111
    localparam logic [5:0] ABX_OP_ANDFILE = 6'h05;  // 00 0101
    localparam logic [3:0] ABX_OP_BITCLR = 4'h4;    // 01 00bb

    // ----------------------------------------
    // Reset values and register map
    // ----------------------------------------
    localparam logic [7:0] ABX_ACC_RST = 8'h00;
    localparam logic [7:0] ABX_FILE_RST = 8'h00;
    localparam logic [31:0] ABX_REG_ACC = 32'h0000_0000;
    localparam logic [31:0] ABX_REG_FLAGS = 32'h0000_0004;
    localparam logic [31:0] ABX_REG_INSN = 32'h0000_0008;
    localparam logic [31:0] ABX_REG_COUNT = 32'h0000_000c;
    localparam logic [31:0] ABX_REG_FILE_BASE = 32'h0000_0200;
    localparam int ABX_FLAG_C = 0;
    localparam int ABX_FLAG_DC = 1;
    localparam int ABX_FLAG_Z = 2;

    typedef enum logic [5:0] {
        ABX_K_NONE = 6'b000001,
        ABX_K_ADDLIT = 6'b000010,
        ABX_K_ANDLIT = 6'b000100,
        ABX_K_ADDFILE = 6'b001000,
        ABX_K_ANDFILE = 6'b010000,
        ABX_K_BITCLR = 6'b100000
    } abx_kind_t;

    typedef struct packed {
        logic carry;
        logic nibble_half_carry;
        logic zero;
    } abx_flags_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } abx_wb_req_t;

endpackage

// file: src/abx_exec_unit.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Add-literal: accumulator plus literal into accumulator; carry, half carry, zero updated.
// - And-literal: accumulator AND literal into accumulator; only zero flag updated.
// - Add-file: accumulator plus file register at 7-bit address; carry, half carry, zero.
// - And-file: accumulator AND file register; only zero flag updated.
// - File ops: destination bit 0 writes accumulator, 1 writes file register.
// - Bit-clear: clear bit 0..7 of file register; flags and other bits unchanged.
// - And-literal replaces accumulator within one instruction cycle; a bus write to file or acc in that cycle holds it back one cycle.
module abx_exec_unit
    import abx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic insn_valid_in,
    input wire logic [13:0] insn_in,
    input wire abx_wb_req_t wb_req_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wb_err_out,
    output logic [7:0] acc_out,
    output abx_flags_t flags_out,
    output logic insn_ready_out
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] acc;
    abx_flags_t flags;
    logic [7:0] file_mem [ABX_FILE_DEPTH];
    logic [13:0] last_insn;
    logic [15:0] exec_count;
    logic ack;
    logic [31:0] rd_data;
    logic [7:0] next_acc;
    abx_flags_t next_flags;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [6:0] f_addr = insn_in[ABX_ADDR_W-1:0];
    wire dest_file = insn_in[ABX_DEST_BIT];
    wire [2:0] bit_sel = insn_in[ABX_BIT_LSB +: 3];
    wire [7:0] literal = insn_in[ABX_DATA_W-1:0];
    wire [7:0] f_val = file_mem[f_addr];
    wire is_addlit = insn_in[13:9] == ABX_OP_ADDLIT;
    wire is_andlit = insn_in[13:8] == ABX_OP_ANDLIT;
    wire is_addfile = insn_in[13:8] == ABX_OP_ADDFILE;
    wire is_andfile = insn_in[13:8] == ABX_OP_ANDFILE;
    wire is_bitclr = insn_in[13:10] == ABX_OP_BITCLR;
    abx_kind_t kind;

    always_comb begin
        kind = ABX_K_NONE;
        if (insn_valid_in) begin
            if (is_addlit) begin
                kind = ABX_K_ADDLIT;
            end else if (is_andlit) begin
                kind = ABX_K_ANDLIT;
            end else if (is_addfile) begin
                kind = ABX_K_ADDFILE;
            end else if (is_andfile) begin
                kind = ABX_K_ANDFILE;
            end else if (is_bitclr) begin
                kind = ABX_K_BITCLR;
            end
        end
    end

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    wire [7:0] add_b = (kind == ABX_K_ADDLIT) ? literal : f_val;
    wire [8:0] sum = {1'b0, acc} + {1'b0, add_b};
    wire [4:0] low_sum = {1'b0, acc[3:0]} + {1'b0, add_b[3:0]};
    wire [7:0] and_b = (kind == ABX_K_ANDLIT) ? literal : f_val;
    wire [7:0] and_res = acc & and_b;
    wire [7:0] clr_res = f_val & ~(8'h01 << bit_sel);
    logic [7:0] result;
    logic wr_file;

    always_comb begin
        next_acc = acc;
        next_flags = flags;  // Unlisted flags hold
        result = 8'h00;
        wr_file = 1'b0;
        case (kind)
            ABX_K_ADDLIT: begin
                next_acc = sum[7:0];
                next_flags = '{sum[8], low_sum[4], sum[7:0] == 8'h00};
            end
            ABX_K_ANDLIT: begin
                next_acc = and_res;
                next_flags.zero = and_res == 8'h00;
            end
            ABX_K_ADDFILE: begin
                result = sum[7:0];
                next_flags = '{sum[8], low_sum[4], sum[7:0] == 8'h00};
                wr_file = dest_file;
                if (!dest_file) begin
                    next_acc = result;
                end
            end
            ABX_K_ANDFILE: begin
                result = and_res;
                next_flags.zero = and_res == 8'h00;
                wr_file = dest_file;
                if (!dest_file) begin
                    next_acc = result;
                end
            end
            ABX_K_BITCLR: begin
                result = clr_res;
                wr_file = 1'b1;
            end
            ABX_K_NONE: begin
                next_acc = acc;
            end
            default: begin
                next_acc = acc;
            end
        endcase
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    wire bus_req = wb_req_in.cyc && wb_req_in.stb && !ack;
    wire bus_wr = bus_req && wb_req_in.we;
    wire [31:0] a = wb_req_in.adr;
    wire hit_file = a[31:9] == ABX_REG_FILE_BASE[31:9] && a[1:0] == 2'b00;
    wire [6:0] bus_faddr = a[8:2];
    wire hit_acc = a == ABX_REG_ACC;
    wire hit_flags = a == ABX_REG_FLAGS;
    wire hit_insn = a == ABX_REG_INSN;
    wire hit_count = a == ABX_REG_COUNT;
    wire hit_any = hit_file || hit_acc || hit_flags || hit_insn || hit_count;
    wire bus_file_wr = bus_wr && hit_file && wb_req_in.sel[0];
    wire bus_acc_wr = bus_wr && hit_acc && wb_req_in.sel[0];
    // Bus writes to file or acc own their cycle; the core waits a cycle
    assign insn_ready_out = !(bus_file_wr || bus_acc_wr);
    wire core_go = insn_ready_out;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_file) begin
            rd_data = {24'h00_0000, file_mem[bus_faddr]};
        end else if (hit_acc) begin
            rd_data = {24'h00_0000, acc};
        end else if (hit_flags) begin
            rd_data = {29'h0000_0000, flags.zero, flags.nibble_half_carry, flags.carry};
        end else if (hit_insn) begin
            rd_data = {18'h0_0000, last_insn};
        end else if (hit_count) begin
            rd_data = {16'h0000, exec_count};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack <= 1'b0;
            wb_err_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            ack <= bus_req;
            wb_err_out <= bus_req && !hit_any;
            wb_dat_out <= rd_data;
        end
    end
    logic hit_any_q;
    assign wb_ack_out = ack && hit_any_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hit_any_q <= 1'b0;
        end else begin
            hit_any_q <= hit_any;
        end
    end

    // ----------------------------------------
    // Architectural registers
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc <= ABX_ACC_RST;
            flags <= '0;
            last_insn <= 14'h0000;
            exec_count <= 16'h0000;
        end else if (bus_acc_wr) begin
            acc <= wb_req_in.dat[7:0];
        end else if (core_go && kind != ABX_K_NONE) begin
            acc <= next_acc;
            flags <= next_flags;
            last_insn <= insn_in;
            exec_count <= exec_count + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (bus_file_wr) begin
            file_mem[bus_faddr] <= wb_req_in.dat[7:0];
        end else if (!rst_in && core_go && wr_file) begin
            file_mem[f_addr] <= result;
        end
    end

    assign acc_out = acc;
    assign flags_out = flags;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    wire go = core_go && !rst_in;
    chk_addlit_sum: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_ADDLIT |=> acc == 8'($past(acc) + $past(literal))
            && flags.carry == (({1'b0, $past(acc)} + {1'b0, $past(literal)}) > 9'h0ff))
        else $error("add literal result wrong");
    chk_andlit_flags: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_ANDLIT |=> flags.carry == $past(flags.carry)
            && flags.nibble_half_carry == $past(flags.nibble_half_carry))
        else $error("and literal touched carry");
    chk_andlit_acc: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_ANDLIT |=> acc == ($past(acc) & $past(literal)))
        else $error("and literal accumulator wrong");
    chk_addfile_half: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_ADDFILE |=> flags.nibble_half_carry
            == (({1'b0, $past(acc[3:0])} + {1'b0, $past(f_val[3:0])}) > 5'h0f))
        else $error("add file half carry wrong");
    chk_andfile_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_ANDFILE |=> flags.zero == (($past(acc) & $past(f_val)) == 8'h00))
        else $error("and file zero wrong");
    chk_dest_acc: assert property (@(posedge clk_in) disable iff (rst_in)
        go && (kind == ABX_K_ADDFILE || kind == ABX_K_ANDFILE) && !dest_file
        |=> acc == $past(result))
        else $error("destination zero missed accumulator");
    chk_bitclr_flags: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_BITCLR |=> $stable(flags) && $stable(acc))
        else $error("bit clear changed state");
    chk_bitclr_file: assert property (@(posedge clk_in) disable iff (rst_in)
        go && kind == ABX_K_BITCLR |=> file_mem[$past(f_addr)]
            == ($past(f_val) & ~(8'h01 << $past(bit_sel))))
        else $error("bit clear file value wrong");
    chk_idle_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        kind == ABX_K_NONE && !bus_acc_wr |=> $stable(acc) && $stable(flags))
        else $error("idle cycle changed state");
    cov_addlit_carry: cover property (@(posedge clk_in) go && kind == ABX_K_ADDLIT && sum[8]);
    cov_file_dest: cover property (@(posedge clk_in) go && kind == ABX_K_ADDFILE && dest_file);
    cov_bitclr: cover property (@(posedge clk_in) go && kind == ABX_K_BITCLR);

endmodule

// file: verification/abx_fetch_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Program memory fetch path
// ----------------------------------------
module abx_fetch_model
    import abx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [13:0] word_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic [13:0] insn_out
);
    // One word per op, held until the core takes it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            insn_out <= 14'h3fff;
        end else if (load_in) begin
            valid_out <= 1'b1;
            insn_out <= word_in;
        end else if (valid_out && ready_in) begin
            valid_out <= 1'b0;
            // Released word is scrambled so a stale read cannot pass
            insn_out <= ~insn_out;
        end
    end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
    import abx_pkg::*;
    logic clk_in, rst_in, load, ready, valid, ack, err, e;
    logic [13:0] word, insn;
    logic [31:0] wb_dat, r;
    logic [7:0] acc;
    abx_wb_req_t wb_req;
    abx_flags_t flags;
    int errors, compares;

    abx_exec_unit abx_exec_unit_inst (.clk_in(clk_in), .rst_in(rst_in),
        .insn_valid_in(valid), .insn_in(insn), .wb_req_in(wb_req), .wb_dat_out(wb_dat),
        .wb_ack_out(ack), .wb_err_out(err), .acc_out(acc), .flags_out(flags),
        .insn_ready_out(ready));
    abx_fetch_model abx_fetch_model_inst (.clk_in(clk_in), .rst_in(rst_in), .load_in(load),
        .word_in(word), .ready_in(ready), .valid_out(valid), .insn_out(insn));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic cf(input logic [2:0] f);
        chk({29'h0, flags}, {29'h0, f}, "flags");
    endtask

    task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_req <= '{adr: a, dat: d, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        r = wb_dat;
        e = err;
        wb_req <= '0;
        if (n >= 20) chk(32'h0, 32'h1, "bus hang");
    endtask

    task automatic ex(input logic [13:0] w);
        int n;
        n = 0;
        @(posedge clk_in);
        load <= 1'b1;
        word <= w;
        @(posedge clk_in);
        load <= 1'b0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (valid === 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1, "insn stuck");
    endtask

    task automatic summarize;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial begin
        repeat (3000) @(posedge clk_in);
        errors++;
        summarize;
    end

    initial begin
        rst_in = 1'b1;
        load = 1'b0;
        word = '0;
        wb_req = '0;
        errors = 0;
        compares = 0;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        chk(acc, 32'h0, "acc reset");
        xfer(1'b1, ABX_REG_ACC, 32'h10);
        ex(14'h3e15);
        chk(acc, 32'h25, "addlit");
        cf(3'b000);
        ex(14'h3fdb);
        chk(acc, 32'h0, "addlit wrap");
        cf(3'b111);
        xfer(1'b0, ABX_REG_FLAGS, 32'h0);
        chk(r, 32'h7, "flags read");
        $display("test add_literal done");
        xfer(1'b1, ABX_REG_ACC, 32'ha3);
        ex(14'h395f);
        chk(acc, 32'h03, "andlit");
        cf(3'b110);
        ex(14'h3900);
        chk(acc, 32'h0, "andlit zero");
        cf(3'b111);
        $display("test and_literal done");
        xfer(1'b1, 32'h3fc, 32'hc2);
        xfer(1'b1, ABX_REG_ACC, 32'h17);
        ex(14'h077f);
        chk(acc, 32'hd9, "addfile acc");
        cf(3'b000);
        xfer(1'b0, 32'h3fc, 32'h0);
        chk(r, 32'hc2, "addfile f kept");
        xfer(1'b1, 32'h214, 32'h0f);
        xfer(1'b1, ABX_REG_ACC, 32'hf1);
        ex(14'h0785);
        xfer(1'b0, 32'h214, 32'h0);
        chk(r, 32'h0, "addfile to f");
        chk(acc, 32'hf1, "addfile acc kept");
        cf(3'b111);
        xfer(1'b1, 32'h210, 32'hc2);
        xfer(1'b1, ABX_REG_ACC, 32'h17);
        ex(14'h0584);
        xfer(1'b0, 32'h210, 32'h0);
        chk(r, 32'h02, "andfile to f");
        chk(acc, 32'h17, "andfile acc kept");
        cf(3'b110);
        $display("test file_ops done");
        xfer(1'b1, 32'h224, 32'hff);
        for (int b = 0; b < 8; b++) begin
            ex({4'b0100, 3'(b), 7'h09});
            xfer(1'b0, 32'h224, 32'h0);
            chk(r, (32'hff << (b + 1)) & 32'hff, "bitclr");
            cf(3'b110);
        end
        chk(acc, 32'h17, "bitclr acc");
        $display("test bit_clear done");
        ex(14'h3a55);
        chk(acc, 32'h17, "unknown op");
        xfer(1'b0, 32'h100, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped err");
        xfer(1'b1, ABX_REG_FLAGS, 32'h0);
        cf(3'b110);
        $display("test refusals done");
        // Bus write to acc lands in the cycle the word is offered
        fork
            ex(14'h3e15);
            begin
                @(posedge clk_in);
                xfer(1'b1, ABX_REG_ACC, 32'h10);
            end
            begin
                repeat (2) @(posedge clk_in);
                #1;
                chk({31'h0, ready}, 32'h0, "stall ready");
            end
        join
        chk(acc, 32'h25, "stalled addlit");
        cf(3'b000);
        xfer(1'b0, ABX_REG_COUNT, 32'h0);
        chk(r, 32'h10, "exec count");
        xfer(1'b0, ABX_REG_INSN, 32'h0);
        chk(r, 32'h3e15, "last insn");
        $display("test stall done");
        summarize;
    end
endmodule
